// file: logic/brake_alarm_seq.sv
// Holding-brake interlock and alarm sequencer with its register file
`include "brake_seq_params.svh"

module brake_alarm_seq #(
   parameter int TICK_CYCLES = `TICK_CYCLES,
   parameter brake_seq_pkg::speed_t MOTOR_MAX_RPM = `MOTOR_MAX_RPM
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic servo_on_n_i,
   input wire logic alarm_clear_in_i,
   input wire logic panel_clear_i,
   input wire logic alarm_event_i,
   input wire brake_seq_pkg::code_t alarm_type_i,
   input wire logic alarm_encoder_i,
   input wire brake_seq_pkg::speed_t motor_speed_i,
   input wire logic [2:0] other_status_on_i,
   input wire brake_seq_pkg::addr_t reg_addr_i,
   input wire brake_seq_pkg::data_t reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output brake_seq_pkg::data_t reg_rdata_o,
   output logic motor_output_en_o,
   output logic [2:0] output_circuit_n_o,
   output logic alarm_status_out_o,
   output logic alarm_code_bit0_o,
   output logic alarm_code_bit1_o,
   output logic alarm_code_bit2_o
);
   import brake_seq_pkg::*;

   brake_timer_if tmr_if ();

   brake_timer #(
      .TICK_CYCLES(TICK_CYCLES)
   ) u_timer (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .tmr(tmr_if.timer)
   );

   // ------------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------------
   logic son_s1_r, son_s2_r, clr_s1_r, clr_s2_r;

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         son_s1_r <= 1'b1;
         son_s2_r <= 1'b1;
         clr_s1_r <= 1'b0;
         clr_s2_r <= 1'b0;
      end else begin
         son_s1_r <= servo_on_n_i;
         son_s2_r <= son_s1_r;
         clr_s1_r <= alarm_clear_in_i;
         clr_s2_r <= clr_s1_r;
      end
   end

   // ------------------------------------------------------------------
   // Register file
   // ------------------------------------------------------------------
   logic brake_fitted_r, brake_fitted_nxt;
   logic enc_hold_r, enc_hold_nxt;
   logic [1:0] brake_output_route_r, brake_output_route_nxt;
   logic [5:0] brake_to_servo_off_delay_r, brake_to_servo_off_delay_nxt;
   speed_t brake_speed_threshold_r, brake_speed_threshold_nxt;
   ticks_t brake_run_timeout_r, brake_run_timeout_nxt;
   logic sw_clear;
   data_t rdata_r, rdata_nxt;
   data_t status_word;

   seq_state_t state_r, state_nxt;
   logic motor_en_r, motor_en_nxt;
   logic brake_rel_r, brake_rel_nxt;
   logic alarm_r, alarm_nxt;
   logic enc_alarm_r, enc_alarm_nxt;
   code_t code_r, code_nxt;

   always_comb begin
      status_word = 16'h0000;
      status_word[`STAT_STATE_HI:`STAT_STATE_LO] = state_r;
      status_word[`STAT_MOTOR_EN] = motor_en_r;
      status_word[`STAT_BRAKE_REL] = brake_rel_r;
      status_word[`STAT_ALARM] = alarm_r;
      status_word[`STAT_ENC_ALARM] = enc_alarm_r;
      status_word[`STAT_CODE_HI:`STAT_CODE_LO] = code_r;
   end

   always_comb begin
      brake_fitted_nxt = brake_fitted_r;
      enc_hold_nxt = enc_hold_r;
      brake_output_route_nxt = brake_output_route_r;
      brake_to_servo_off_delay_nxt = brake_to_servo_off_delay_r;
      brake_speed_threshold_nxt = brake_speed_threshold_r;
      brake_run_timeout_nxt = brake_run_timeout_r;
      sw_clear = 1'b0;
      rdata_nxt = 16'h0000;
      if (reg_wr_i) begin
         case (reg_addr_i)
            `REG_CTRL: begin
               brake_fitted_nxt = reg_wdata_i[`CTRL_BRAKE_FITTED];
               enc_hold_nxt = reg_wdata_i[`CTRL_ENC_HOLD];
               brake_output_route_nxt = reg_wdata_i[`CTRL_ROUTE_HI:`CTRL_ROUTE_LO];
               sw_clear = reg_wdata_i[`CTRL_CLEAR];
            end
            `REG_DELAY: begin
               // Out-of-range writes saturate so the timer never sees a bad value
               brake_to_servo_off_delay_nxt = (reg_wdata_i[5:0] > `DELAY_MAX) ?
                  `DELAY_MAX : reg_wdata_i[5:0];
            end
            `REG_SPEED: begin
               brake_speed_threshold_nxt = (reg_wdata_i[13:0] > `SPEED_MAX) ?
                  `SPEED_MAX : reg_wdata_i[13:0];
            end
            `REG_TIMEOUT: begin
               brake_run_timeout_nxt = (reg_wdata_i[6:0] > `TIMEOUT_MAX) ?
                  `TIMEOUT_MAX : reg_wdata_i[6:0];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd_i) begin
         case (reg_addr_i)
            `REG_CTRL: begin
               rdata_nxt = {12'h000, brake_output_route_r, enc_hold_r, brake_fitted_r};
            end
            `REG_DELAY: begin
               rdata_nxt = {10'h000, brake_to_servo_off_delay_r};
            end
            `REG_SPEED: begin
               rdata_nxt = {2'h0, brake_speed_threshold_r};
            end
            `REG_TIMEOUT: begin
               rdata_nxt = {9'h000, brake_run_timeout_r};
            end
            `REG_STATUS: begin
               rdata_nxt = status_word;
            end
            default: begin
               rdata_nxt = 16'h0000;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         brake_fitted_r <= 1'(`CTRL_RESET >> `CTRL_BRAKE_FITTED);
         enc_hold_r <= 1'b0;
         brake_output_route_r <= 2'h0;
         brake_to_servo_off_delay_r <= `DELAY_RESET;
         brake_speed_threshold_r <= `SPEED_RESET;
         brake_run_timeout_r <= `TIMEOUT_RESET;
         rdata_r <= 16'h0000;
      end else begin
         brake_fitted_r <= brake_fitted_nxt;
         enc_hold_r <= enc_hold_nxt;
         brake_output_route_r <= brake_output_route_nxt;
         brake_to_servo_off_delay_r <= brake_to_servo_off_delay_nxt;
         brake_speed_threshold_r <= brake_speed_threshold_nxt;
         brake_run_timeout_r <= brake_run_timeout_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata_o = rdata_r;

   // ------------------------------------------------------------------
   // Alarm latch
   // ------------------------------------------------------------------
   logic any_clear;

   always_comb begin
      any_clear = clr_s2_r | panel_clear_i | sw_clear;
      alarm_nxt = alarm_r;
      enc_alarm_nxt = enc_alarm_r;
      code_nxt = code_r;
      // An encoder alarm held by policy survives every clear but reset
      if (any_clear && !(enc_alarm_r && enc_hold_r)) begin
         alarm_nxt = 1'b0;
         enc_alarm_nxt = 1'b0;
         code_nxt = 3'h0;
      end
      // A new alarm wins over a clear in the same cycle
      if (alarm_event_i) begin
         alarm_nxt = 1'b1;
         enc_alarm_nxt = alarm_encoder_i | (enc_alarm_r & alarm_r & enc_hold_r);
         code_nxt = alarm_type_i;
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         alarm_r <= 1'b0;
         enc_alarm_r <= 1'b0;
         code_r <= 3'h0;
      end else begin
         alarm_r <= alarm_nxt;
         enc_alarm_r <= enc_alarm_nxt;
         code_r <= code_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Brake sequencer
   // ------------------------------------------------------------------
   speed_t eff_threshold;
   logic slow;
   logic servo_req;
   logic alarm_act;

   always_comb begin
      eff_threshold = (brake_speed_threshold_r > MOTOR_MAX_RPM) ?
         MOTOR_MAX_RPM : brake_speed_threshold_r;
      slow = (motor_speed_i < eff_threshold);
      servo_req = ~son_s2_r;
      alarm_act = alarm_r | alarm_event_i;
      state_nxt = state_r;
      tmr_if.load = 1'b0;
      tmr_if.load_ticks = 7'h00;
      case (state_r)
         ST_OFF: begin
            if (servo_req && !alarm_act) begin
               state_nxt = ST_ON;
            end
         end
         ST_ON: begin
            if (alarm_act) begin
               // Power to the motor is cut now; the brake waits for the shaft
               state_nxt = slow ? ST_OFF : ST_RUN_OFF;
               tmr_if.load = !slow;
               tmr_if.load_ticks = brake_run_timeout_r;
            end else if (!servo_req) begin
               if (!slow) begin
                  state_nxt = ST_RUN_OFF;
                  tmr_if.load = 1'b1;
                  tmr_if.load_ticks = brake_run_timeout_r;
               end else if (brake_to_servo_off_delay_r == 6'h00) begin
                  state_nxt = ST_OFF;
               end else begin
                  state_nxt = ST_STOP_DELAY;
                  tmr_if.load = 1'b1;
                  tmr_if.load_ticks = {1'b0, brake_to_servo_off_delay_r};
               end
            end
         end
         ST_STOP_DELAY: begin
            if (alarm_act || tmr_if.expired) begin
               state_nxt = ST_OFF;
            end
         end
         ST_RUN_OFF: begin
            if (slow || tmr_if.expired) begin
               state_nxt = ST_OFF;
            end
         end
         default: begin
            state_nxt = ST_OFF;
         end
      endcase
      motor_en_nxt = (state_nxt == ST_ON) || (state_nxt == ST_STOP_DELAY);
      brake_rel_nxt = brake_fitted_r &&
         ((state_nxt == ST_ON) || (state_nxt == ST_RUN_OFF));
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         state_r <= ST_OFF;
         motor_en_r <= 1'b0;
         brake_rel_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         motor_en_r <= motor_en_nxt;
         brake_rel_r <= brake_rel_nxt;
      end
   end

   // ------------------------------------------------------------------
   // Output circuits and alarm pins
   // ------------------------------------------------------------------
   logic [2:0] circuit_n_r, circuit_n_nxt;
   logic alarm_pin_r;
   code_t code_pin_r;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++) begin : g_circuit
         // Closed (low) when any signal routed here is on
         always_comb begin
            circuit_n_nxt[gi] = ~((brake_rel_nxt && (brake_output_route_r == 2'(gi + 1))) ||
               other_status_on_i[gi]);
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         circuit_n_r <= 3'h7;
         alarm_pin_r <= 1'b0;
         code_pin_r <= 3'h0;
      end else begin
         circuit_n_r <= circuit_n_nxt;
         alarm_pin_r <= alarm_nxt;
         code_pin_r <= code_nxt;
      end
   end

   assign motor_output_en_o = motor_en_r;
   assign output_circuit_n_o = circuit_n_r;
   assign alarm_status_out_o = alarm_pin_r;
   assign alarm_code_bit0_o = code_pin_r[0];
   assign alarm_code_bit1_o = code_pin_r[1];
   assign alarm_code_bit2_o = code_pin_r[2];

endmodule : brake_alarm_seq

// file: logic/brake_seq_params.svh
// Offsets, field positions, reset values and timing counts of the brake and alarm sequencer
`ifndef BRAKE_SEQ_PARAMS_SVH
`define BRAKE_SEQ_PARAMS_SVH

// ------------------------------------------------------------------
// Register offsets (word register file, 4-bit address)
// ------------------------------------------------------------------
`define REG_CTRL 4'h0
`define REG_DELAY 4'h1
`define REG_SPEED 4'h2
`define REG_TIMEOUT 4'h3
`define REG_STATUS 4'h4

// ------------------------------------------------------------------
// Control register fields
// ------------------------------------------------------------------
`define CTRL_BRAKE_FITTED 0
`define CTRL_ENC_HOLD 1
`define CTRL_ROUTE_LO 2
`define CTRL_ROUTE_HI 3
`define CTRL_CLEAR 4

// ------------------------------------------------------------------
// Status register fields
// ------------------------------------------------------------------
`define STAT_STATE_LO 0
`define STAT_STATE_HI 3
`define STAT_MOTOR_EN 4
`define STAT_BRAKE_REL 5
`define STAT_ALARM 6
`define STAT_ENC_ALARM 7
`define STAT_CODE_LO 8
`define STAT_CODE_HI 10

// ------------------------------------------------------------------
// Reset values and setting limits
// ------------------------------------------------------------------
`define CTRL_RESET 8'h00
`define DELAY_RESET 6'h00
`define DELAY_MAX 6'h32
`define SPEED_RESET 14'h0064
`define SPEED_MAX 14'h2710
`define TIMEOUT_RESET 7'h32
`define TIMEOUT_MAX 7'h64
`define MOTOR_MAX_RPM 14'h1770

// ------------------------------------------------------------------
// Timing
// ------------------------------------------------------------------
`define CLK_PERIOD_NS 20
`define TICK_TIME_MS 10
`define TICK_CYCLES ((`TICK_TIME_MS * 1000000) / `CLK_PERIOD_NS)

`endif

// file: logic/brake_seq_pkg.sv
// Types shared by the brake and alarm sequencer
package brake_seq_pkg;

   typedef logic [13:0] speed_t;
   typedef logic [2:0] code_t;
   typedef logic [3:0] addr_t;
   typedef logic [15:0] data_t;
   typedef logic [6:0] ticks_t;

   typedef enum logic [3:0] {
      ST_OFF = 4'h1,
      ST_ON = 4'h2,
      ST_STOP_DELAY = 4'h4,
      ST_RUN_OFF = 4'h8
   } seq_state_t;

endpackage : brake_seq_pkg

// file: logic/brake_timer.sv
// Loadable down counter in 10 ms ticks
`include "brake_seq_params.svh"
module brake_timer #(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   brake_timer_if.timer tmr
);
   import brake_seq_pkg::*;

   logic [31:0] pre_r, pre_nxt;
   ticks_t cnt_r, cnt_nxt;
   logic run_r, run_nxt;

   // ------------------------------------------------------------------
   // Counter
   // ------------------------------------------------------------------
   // Loading restarts the prescaler so a delay of N is exactly N ticks
   always_comb begin
      pre_nxt = pre_r;
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      if (tmr.load) begin
         pre_nxt = 32'h0;
         cnt_nxt = tmr.load_ticks;
         run_nxt = (tmr.load_ticks != 7'h00);
      end else if (run_r) begin
         if (pre_r == 32'(TICK_CYCLES - 1)) begin
            pre_nxt = 32'h0;
            cnt_nxt = cnt_r - 7'h01;
            if (cnt_r == 7'h01) begin
               run_nxt = 1'b0;
            end
         end else begin
            pre_nxt = pre_r + 32'h1;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         pre_r <= 32'h0;
         cnt_r <= 7'h00;
         run_r <= 1'b0;
      end else begin
         pre_r <= pre_nxt;
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
      end
   end

   assign tmr.expired = ~run_r;

endmodule : brake_timer

// file: logic/brake_timer_if.sv
// Load and expiry signals between the sequencer and its 10 ms timer
interface brake_timer_if;
   import brake_seq_pkg::*;

   logic load;
   ticks_t load_ticks;
   logic expired;

   modport seq (output load, output load_ticks, input expired);
   modport timer (input load, input load_ticks, output expired);

endinterface : brake_timer_if

// file: verification/brake_alarm_seq_asserts.sv
// Port-level assertions for the brake and alarm sequencer
module brake_alarm_seq_asserts #(
   parameter int TICK_CYCLES = 10
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic servo_on_n_i,
   input wire logic alarm_clear_in_i,
   input wire logic panel_clear_i,
   input wire logic alarm_event_i,
   input wire brake_seq_pkg::code_t alarm_type_i,
   input wire logic alarm_encoder_i,
   input wire logic [2:0] other_status_on_i,
   input wire logic reg_rd_i,
   input wire brake_seq_pkg::data_t reg_rdata_o,
   input wire logic motor_output_en_o,
   input wire logic [2:0] output_circuit_n_o,
   input wire logic alarm_status_out_o,
   input wire logic alarm_code_bit0_o,
   input wire logic alarm_code_bit1_o,
   input wire logic alarm_code_bit2_o
);
   import brake_seq_pkg::*;
   // Encoder alarms may be held, so clear checks skip them
   logic enc_r, enc_nxt;
   always_comb begin
      enc_nxt = enc_r;
      if (alarm_event_i) enc_nxt = enc_r | alarm_encoder_i;
      else if (!alarm_status_out_o) enc_nxt = 1'b0;
   end
   always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) enc_r <= 1'b0;
      else enc_r <= enc_nxt;
   end
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   property p_alarm_set;
      alarm_event_i |=> alarm_status_out_o && !motor_output_en_o;
   endproperty
   a_alarm_set: assert property (p_alarm_set) else $error("alarm not latched");
   property p_alarm_code;
      alarm_event_i |=>
         {alarm_code_bit2_o, alarm_code_bit1_o, alarm_code_bit0_o} == $past(alarm_type_i);
   endproperty
   a_alarm_code: assert property (p_alarm_code) else $error("alarm code wrong");
   property p_alarm_motor;
      alarm_status_out_o |-> !motor_output_en_o;
   endproperty
   a_alarm_motor: assert property (p_alarm_motor) else $error("motor on in alarm");
   property p_panel_clear;
      panel_clear_i && !alarm_event_i && !enc_r |=> !alarm_status_out_o;
   endproperty
   a_panel_clear: assert property (p_panel_clear) else $error("panel clear lost");
   property p_pin_clear;
      (alarm_clear_in_i && !alarm_event_i && !enc_r) [*4] |=> !alarm_status_out_o;
   endproperty
   a_pin_clear: assert property (p_pin_clear) else $error("clear pin ignored");
   property p_or_circuit;
      |other_status_on_i |=> (output_circuit_n_o & $past(other_status_on_i)) == 3'h0;
   endproperty
   a_or_circuit: assert property (p_or_circuit) else $error("circuit not ORed");
   property p_servo_rise;
      $rose(motor_output_en_o) |-> !$past(servo_on_n_i, 3) && !alarm_status_out_o;
   endproperty
   a_servo_rise: assert property (p_servo_rise) else $error("motor on unasked");
   property p_rd_idle;
      !reg_rd_i |=> reg_rdata_o == 16'h0000;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
   c_alarm: cover property (alarm_event_i);
   c_stop: cover property ($fell(motor_output_en_o));
   c_panel: cover property (panel_clear_i && alarm_status_out_o);
endmodule : brake_alarm_seq_asserts

bind brake_alarm_seq brake_alarm_seq_asserts #(.TICK_CYCLES(TICK_CYCLES)) i_chk (
   .sys_clk_i, .sys_rst_i, .servo_on_n_i, .alarm_clear_in_i, .panel_clear_i,
   .alarm_event_i, .alarm_type_i, .alarm_encoder_i, .other_status_on_i, .reg_rd_i,
   .reg_rdata_o, .motor_output_en_o, .output_circuit_n_o, .alarm_status_out_o,
   .alarm_code_bit0_o, .alarm_code_bit1_o, .alarm_code_bit2_o);

// file: verification/brake_alarm_seq_tb_top.sv
// Self-checking bench for the brake and alarm sequencer
module brake_alarm_seq_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import brake_seq_pkg::*;
   localparam int TK = 10;
   logic sys_clk, sys_rst, servo_on_n, alm_clr, panel_clr, alm_ev, alm_enc, reg_wr, reg_rd;
   logic motor_en, alm_out, c0, c1, c2;
   logic [2:0] other_on, circ_n;
   code_t alm_type;
   speed_t target, decel, speed;
   addr_t addr;
   data_t wdata, rdata;
   data_t msk [3] = '{16'h003f, 16'h3fff, 16'h007f};
   data_t mx [3] = '{16'h0032, 16'h2710, 16'h0064};
   int errors, cmp_count, tb, tm, sp;

   brake_alarm_seq #(.TICK_CYCLES(TK)) i_dut (
      .sys_clk_i(sys_clk), .sys_rst_i(sys_rst), .servo_on_n_i(servo_on_n),
      .alarm_clear_in_i(alm_clr), .panel_clear_i(panel_clr), .alarm_event_i(alm_ev),
      .alarm_type_i(alm_type), .alarm_encoder_i(alm_enc), .motor_speed_i(speed),
      .other_status_on_i(other_on), .reg_addr_i(addr), .reg_wdata_i(wdata),
      .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(rdata),
      .motor_output_en_o(motor_en), .output_circuit_n_o(circ_n),
      .alarm_status_out_o(alm_out), .alarm_code_bit0_o(c0), .alarm_code_bit1_o(c1),
      .alarm_code_bit2_o(c2));
   motor_load_model i_load (.clk_i(sys_clk), .rst_i(sys_rst), .motor_en_i(motor_en),
      .alarm_i(alm_out), .target_i(target), .decel_i(decel), .speed_o(speed));

   // --------------------------------------------------------------
   // Expectations and checks
   // --------------------------------------------------------------
   function automatic data_t sat(data_t v, data_t m, data_t top);
      return ((v & m) > top) ? top : (v & m);
   endfunction : sat
   function automatic logic [2:0] circ_exp(logic [1:0] r, logic [2:0] oth);
      return ~(oth | ((r != 2'h0) ? 3'(1 << (r - 1)) : 3'h0));
   endfunction : circ_exp
   task automatic chk(data_t got, data_t exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic end_of_test;
      $display("errors=%0d compares=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : end_of_test

   // --------------------------------------------------------------
   // Drivers
   // --------------------------------------------------------------
   task automatic tick(int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : tick
   task automatic wr_reg(addr_t a, data_t d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(addr_t a, data_t e);
      @(posedge sys_clk);
      addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(rdata, e);
   endtask : rd_chk
   task automatic wait_on;
      int n;
      for (n = 0; n < 50 && motor_en !== 1'b1; n++) tick(1);
      chk(motor_en, 16'h0001);
   endtask : wait_on
   // Counts cycles from servo off until brake applied (tb) and motor off (tm)
   task automatic stop_seq(logic [1:0] r);
      int n;
      tb = -1;
      tm = -1;
      @(posedge sys_clk);
      servo_on_n <= 1'b1;
      for (n = 0; n < 2000 && (tb < 0 || tm < 0); n++) begin
         tick(1);
         if (tb < 0 && circ_n[r - 1] === 1'b1) begin
            tb = n;
            sp = speed;
         end
         if (tm < 0 && motor_en === 1'b0) tm = n;
      end
      chk(tb >= 0 && tm >= 0, 16'h0001);
   endtask : stop_seq
   task automatic run_stop(logic [1:0] r, data_t d, data_t to, data_t thr, speed_t tg,
         speed_t dc);
      wr_reg(4'h0, {12'h000, r, 2'b01});
      wr_reg(4'h1, d);
      wr_reg(4'h2, thr);
      wr_reg(4'h3, to);
      @(posedge sys_clk);
      target <= tg;
      decel <= dc;
      other_on <= 3'($urandom) & ~3'(1 << (r - 1));
      servo_on_n <= 1'b0;
      wait_on();
      tick(2);
      chk(circ_n, circ_exp(r, other_on));
      stop_seq(r);
   endtask : run_stop
   task automatic alarm(code_t c, logic e);
      @(posedge sys_clk);
      alm_ev <= 1'b1;
      alm_type <= c;
      alm_enc <= e;
      @(posedge sys_clk);
      alm_ev <= 1'b0;
      #1;
   endtask : alarm
   // The alarm cause is gone before any clear is asked for
   task automatic clear(logic pin);
      @(posedge sys_clk);
      if (pin) alm_clr <= 1'b1;
      else panel_clr <= 1'b1;
      repeat (pin ? 4 : 1) @(posedge sys_clk);
      alm_clr <= 1'b0;
      panel_clr <= 1'b0;
      tick(1);
   endtask : clear

   // --------------------------------------------------------------
   // Clock, watchdog and main sequence
   // --------------------------------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   initial begin
      repeat (60000) @(posedge sys_clk);
      errors++;
      end_of_test();
   end
   initial begin
      int i, d, to;
      errors = 0;
      cmp_count = 0;
      void'($urandom(36967));
      {servo_on_n, alm_clr, panel_clr, alm_ev, alm_enc, reg_wr, reg_rd} = 7'h40;
      {alm_type, other_on, addr, wdata, target, decel} = '0;
      sys_rst = 1'b1;
      repeat (3) @(posedge sys_clk);
      sys_rst <= 1'b0;
      tick(1);
      chk({motor_en, circ_n, alm_out, c2, c1, c0}, 16'h0070);
      rd_chk(4'h0, 16'h0000);
      rd_chk(4'h1, 16'h0000);
      rd_chk(4'h2, 16'h0064);
      rd_chk(4'h3, 16'h0032);
      rd_chk(4'h4, 16'h0001);
      rd_chk(4'h5, 16'h0000);
      for (i = 0; i < 9; i++) begin
         d = (i < 3) ? 16'hffff : $urandom;
         wr_reg(addr_t'(i % 3 + 1), data_t'(d));
         rd_chk(addr_t'(i % 3 + 1), sat(data_t'(d), msk[i % 3], mx[i % 3]));
      end
      for (i = 1; i < 4; i++) begin
         d = (i == 1) ? 0 : $urandom_range(5, 1);
         run_stop(2'(i), data_t'(d), 16'h0032, 16'h0064, 14'h0032, 14'h0000);
         chk(tb <= 3, 16'h0001);
         chk(tm - tb >= d * TK && tm - tb <= d * TK + (d ? 2 : 0), 16'h0001);
      end
      run_stop(2'h2, 16'h0000, 16'h0064, 16'h0064, 14'h0bb8, 14'h0014);
      chk(tm < tb && sp < 100 && sp >= 40, 16'h0001);
      to = $urandom_range(8, 1);
      run_stop(2'h3, 16'h0000, data_t'(to), 16'h0064, 14'h0bb8, 14'h0000);
      chk(tm <= 3 && tb >= to * TK && tb <= to * TK + 6, 16'h0001);
      run_stop(2'h1, 16'h0005, 16'h0001, 16'h2710, 14'h1b58, 14'h0000);
      chk(tm < tb, 16'h0001);
      wr_reg(4'h0, 16'h0004);
      wr_reg(4'h2, 16'h0064);
      @(posedge sys_clk);
      other_on <= 3'h0;
      target <= 14'h0032;
      servo_on_n <= 1'b0;
      wait_on();
      tick(2);
      chk(circ_n, 16'h0007);
      wr_reg(4'h0, 16'h0005);
      for (i = 0; i < 8; i++) begin
         wait_on();
         alarm(3'(i), 1'b0);
         chk({motor_en, circ_n[0], alm_out, c2, c1, c0}, {10'h000, 3'h3, 3'(i)});
         tick(4);
         chk(motor_en, 16'h0000);
         clear(i[0]);
         chk(alm_out, 16'h0000);
      end
      wr_reg(4'h0, 16'h0007);
      alarm(3'h5, 1'b1);
      clear(1'b0);
      chk(alm_out, 16'h0001);
      rd_chk(4'h4, 16'h05c1);
      // Hold policy is dropped first, so the register clear acts on the next write
      wr_reg(4'h0, 16'h0005);
      wr_reg(4'h0, 16'h0015);
      tick(1);
      chk(alm_out, 16'h0000);
      alarm(3'h6, 1'b1);
      @(posedge sys_clk);
      sys_rst <= 1'b1;
      @(posedge sys_clk);
      sys_rst <= 1'b0;
      tick(1);
      chk({alm_out, c2, c1, c0}, 16'h0000);
      end_of_test();
   end
endmodule : brake_alarm_seq_tb_top

// file: verification/motor_load_model.sv
// Host-side motor load model: speed follows target while powered, coasts when not
module motor_load_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic motor_en_i,
   input wire logic alarm_i,
   input wire brake_seq_pkg::speed_t target_i,
   input wire brake_seq_pkg::speed_t decel_i,
   output brake_seq_pkg::speed_t speed_o
);
   import brake_seq_pkg::*;
   // Zero decel keeps the shaft spinning, which forces the timeout path when speed is at or above the brake speed threshold
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         speed_o <= 14'h0000;
      else if (motor_en_i && !alarm_i)
         speed_o <= target_i;
      else if (speed_o > decel_i)
         speed_o <= speed_o - decel_i;
      else
         speed_o <= 14'h0000;
   end
endmodule : motor_load_model
